// ===== ipw_arbiter.sv
// Priority arbiter: maps level fields to sources and picks the most urgent request
`timescale 1ns/100ps
module ipw_arbiter
  import ipw_pkg::*;
(
  // Configuration
  input wire logic [15:0] prio_fields,
  // Requests already gated by mask
  input wire logic [NUM_PER-1:0] req,
  input wire logic ext_req,
  // Result
  output logic found,
  output logic [2:0] code,
  output logic [2:0] level
);

  // Scan from level 5 upward to level 1 so the most urgent hit ends last
  always_comb begin
    logic [2:0] f;
    f = 3'h0;
    found = 1'b0;
    code = 3'h0;
    level = LEVEL_MAIN;
    for (int i = NUM_LEVELS; i >= 1; i--) begin
      f = prio_fields[(i-1)*FIELD_W +: FIELD_W];
      if (f < 3'(NUM_PER) && req[f]) begin
        found = 1'b1;
        code = f;
        level = 3'(i);
      end
    end
    // External pin is fixed at level 0 and beats everything
    if (ext_req) begin
      found = 1'b1;
      code = CODE_EXT;
      level = 3'h0;
    end
  end

endmodule

// ===== ipw_monitor.sv
// Port-level checker for the interrupt priority and power wake block
`timescale 1ns/100ps
module ipw_monitor
  import ipw_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Watched inputs
  input wire logic reset_pin_n,
  input wire logic wdg_reset,
  input wire logic wdg_enabled,
  input wire logic halt_instr,
  input wire logic ext_request,
  // Watched outputs
  input wire logic take_irq,
  input wire logic [7:0] vector_addr,
  input wire logic [2:0] active_level,
  input wire logic save_context,
  input wire logic cpu_run,
  input wire logic osc_enable,
  input wire logic periph_enable,
  input wire logic [3:0] power_state
);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  take_pulse_a: assert property (take_irq |=> !take_irq)
    else $error("take_irq held longer than one cycle");
  vector_table_a: assert property (take_irq |-> vector_addr inside {3, 6, 9, 12, 15, 18})
    else $error("vector outside the table");
  ext_level_a: assert property (take_irq && vector_addr == 8'h12 |-> active_level == 3'h0)
    else $error("external routine not at level zero");
  level_range_a: assert property (active_level <= LEVEL_MAIN)
    else $error("active level above six");
  context_save_a: assert property (take_irq |-> save_context)
    else $error("vectoring without context save");
  halt_off_a: assert property (power_state == PS_HALT |-> !osc_enable && !cpu_run && !periph_enable)
    else $error("activity while halted");
  wait_mode_a: assert property (power_state == PS_WAIT |-> !cpu_run && osc_enable && periph_enable)
    else $error("wait mode outputs wrong");
  halt_skip_a: assert property (wdg_enabled && halt_instr && power_state == PS_RUN |=> power_state != PS_HALT)
    else $error("halt entered with watchdog on");
  halt_hold_a: assert property ($past(power_state) == PS_HALT && power_state == PS_HALT
    && !$past(ext_request) && !ext_request && reset_pin_n && !wdg_reset
    |=> power_state == PS_HALT)
    else $error("halt left without external request");
  pin_reset_a: assert property (!reset_pin_n |=> active_level == LEVEL_MAIN && !take_irq)
    else $error("reset pin not acting at once");
endmodule
bind ipw_top ipw_monitor mon_u (.mclk(mclk), .rst(rst), .reset_pin_n(reset_pin_n),
  .wdg_reset(wdg_reset), .wdg_enabled(wdg_enabled), .halt_instr(halt_instr),
  .ext_request(ext_request), .take_irq(take_irq), .vector_addr(vector_addr),
  .active_level(active_level), .save_context(save_context), .cpu_run(cpu_run),
  .osc_enable(osc_enable), .periph_enable(periph_enable), .power_state(power_state));

// ===== ipw_pkg.sv
// Package of constants and types for the interrupt priority and power wake block
// Functional notes
// - Seven priority levels 0..6; level 0 most urgent, level 6 least urgent.
// - Level 6 is main program, level 0 external pin, levels 5..1 software assigned.
// - Each peripheral has a 3-bit code; writing it into level-i field gives level i.
// - Codes: converter 000, timer zero 001, timer one 010, timer two 011, serial 100.
// - Level fields are 3-bit slices 0-2,3-5,6-8,9-11,12-14 over two registers.
// - An enabled request makes the control unit jump to the source's vector.
// - Return resumes at the instruction right after the interrupted one.
// - Any source wakes from wait; only the external pin wakes from halt.
// - Clear-pending with operand j cancels source j's pending request.
// - Clearing own pending request inside its routine drops it to least urgent level.
// - Reset from pin or watchdog restarts the program; internal reset never drives pin.
// - External reset acts at once; the reset pin is high for normal operation.
// - Wait stops execution, clock and peripherals run; interrupt or reset exits.
// - Halt turns off the oscillator, stopping all processing and peripherals.
// - Halt while watchdog enabled is a no-operation.
// - Leaving halt waits 4096 cycles after interrupt, 1000000 after reset.
// - After interrupt wake-up, the external interrupt routine runs first.
// - Masked external interrupt still exits halt but vectors to least urgent routine.
// - At end of each ALU instruction pick most urgent unmasked request; save flags, PC.
// - Mask bit 1 enables a source; masked requests stay pending.
// - Vectors are three-byte entries in program memory locations 3 through 20.
package ipw_pkg;

  // ****************************************************************
  // Register map and field layout
  // ****************************************************************
  localparam logic [7:0] ADDR_PRIO_LOW = 8'h11;
  localparam logic [7:0] ADDR_PRIO_HIGH = 8'h12;
  localparam logic [7:0] ADDR_MASK = 8'h00;
  localparam logic [7:0] PRIO_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam int FIELD_W = 3;
  localparam int NUM_PER = 5;
  localparam int NUM_LEVELS = 5;
  localparam int MASK_EXT_BIT = 0;

  // ****************************************************************
  // Source codes and vector layout
  // ****************************************************************
  localparam logic [2:0] CODE_ADC = 3'h0;
  localparam logic [2:0] CODE_TMR0 = 3'h1;
  localparam logic [2:0] CODE_TMR1 = 3'h2;
  localparam logic [2:0] CODE_TMR2 = 3'h3;
  localparam logic [2:0] CODE_SCI = 3'h4;
  localparam logic [2:0] CODE_EXT = 3'h5;
  localparam logic [7:0] VEC_BASE = 8'h03;
  localparam logic [7:0] VEC_STRIDE = 8'h03;
  localparam logic [2:0] LEVEL_MAIN = 3'h6;

  // ****************************************************************
  // Stabilisation delays
  // ****************************************************************
  localparam int STAB_INT_CYC = 4096;
  localparam int STAB_RST_CYC = 1000000;
  localparam int CNT_W = 20;

  // Power state, one-hot
  typedef enum logic [3:0] {
    PS_RUN = 4'h1,
    PS_WAIT = 4'h2,
    PS_HALT = 4'h4,
    PS_STAB = 4'h8
  } ipw_pstate_t;

endpackage

// ===== ipw_src_model.sv
// Peripheral request model: turns command levels into one-cycle request pulses
`timescale 1ns/100ps
module ipw_src_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Command from the bench and pulses to the block
  input wire logic [5:0] fire,
  output logic [5:0] req
);
  logic [5:0] fire_d;
  // Rising edge of a command gives one pulse, as real sources flag an event once
  always_ff @(posedge mclk) begin
    fire_d <= rst ? 6'h00 : fire;
    req <= rst ? 6'h00 : (fire & ~fire_d);
  end
endmodule

// ===== ipw_stab_timer.sv
// Oscillator stabilisation down-counter
`timescale 1ns/100ps
module ipw_stab_timer
  import ipw_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic [CNT_W-1:0] load_val,
  // Status
  output logic done
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic done;
  } ipw_tmr_t;

  ipw_tmr_t s_r;
  ipw_tmr_t s_nxt;

  // Count down one per clock; done pulses on the last cycle
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (load) begin
      s_nxt.cnt = load_val;
    end else if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
      if (s_r.cnt == CNT_W'(1)) begin
        s_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign done = s_r.done;

endmodule

// ===== ipw_top.sv
// Interrupt priority arbitration, pending flags and wait/halt power control
`timescale 1ns/100ps
module ipw_top
  import ipw_pkg::*;
#(
  parameter int STAB_INT = STAB_INT_CYC,
  parameter int STAB_RST = STAB_RST_CYC
)
(
  // Clock and resets
  input wire logic mclk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic wdg_reset,
  input wire logic wdg_enabled,
  // Configuration write port from the control unit
  input wire logic cfg_we,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  // Configuration read port
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  // Interrupt sources, one-cycle event pulses
  input wire logic adc_request,
  input wire logic timer_zero_request,
  input wire logic timer_one_request,
  input wire logic timer_two_request,
  input wire logic sci_request,
  input wire logic ext_request,
  // Control unit instruction events
  input wire logic alu_instr_end,
  input wire logic return_instr,
  input wire logic clear_pending_instruction,
  input wire logic [2:0] clear_index,
  input wire logic wait_instr,
  input wire logic halt_instr,
  input wire logic user_global_disable,
  input wire logic user_global_enable,
  input wire logic macro_global_disable,
  input wire logic macro_global_enable,
  // Vectoring to the control unit
  output logic take_irq,
  output logic [7:0] vector_addr,
  output logic [2:0] active_level,
  output logic save_context,
  output logic restore_context,
  // Power and reset control
  output logic cpu_run,
  output logic osc_enable,
  output logic periph_enable,
  output logic program_restart,
  output logic [3:0] power_state
);

  // Elaboration check: both delays must fit the stabilisation counter
  if (STAB_INT < 1 || STAB_RST < 1 || STAB_RST >= (1 << CNT_W) ||
      STAB_INT >= (1 << CNT_W)) begin : g_stab_range
    $error("stabilisation counts out of range");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] prio_lo;
    logic [7:0] prio_hi;
    logic [7:0] mask;
    logic [NUM_PER:0] pend;
    logic user_gie;
    logic macro_gie;
    logic [2:0] cur_level;
    logic [2:0] cur_code;
    // Eight frames; deeper nesting wraps, which software must not allow
    logic [7:0][5:0] stack;
    logic [2:0] sp;
    ipw_pstate_t pst;
    logic halt_by_ext;
    logic take_irq;
    logic [7:0] vector_addr;
    logic save_context;
    logic restore_context;
    logic program_restart;
    logic [7:0] rd_data;
    logic cpu_run;
    logic osc_en;
    logic periph_en;
  } ipw_state_t;

  ipw_state_t s_r;
  ipw_state_t s_nxt;

  // Vector address of a source code: three bytes per entry from location 3
  function automatic logic [7:0] vec_of(input logic [2:0] c);
    logic [7:0] p;
    p = 8'(c) * VEC_STRIDE;
    return VEC_BASE + p;
  endfunction

  // Least urgent level holding a real source code, as {level, code}
  function automatic logic [5:0] least_src(input logic [15:0] f);
    logic [2:0] c;
    // All fields unassigned is a setup fault; the converter is the fallback
    least_src = {3'(NUM_LEVELS), CODE_ADC};
    for (int i = 1; i <= NUM_LEVELS; i++) begin
      c = f[(i-1)*FIELD_W +: FIELD_W];
      if (c < 3'(NUM_PER)) begin
        least_src = {3'(i), c};
      end
    end
  endfunction

  // ****************************************************************
  // Arbitration and stabilisation timer
  // ****************************************************************
  logic [NUM_PER-1:0] per_req;
  logic ext_gated;
  logic arb_found;
  logic [2:0] arb_code;
  logic [2:0] arb_level;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_val;
  logic tmr_done;
  logic ext_rst;
  logic halt_rst;

  // Masked requests stay in the pending set and simply do not compete
  assign per_req = s_r.pend[NUM_PER-1:0] & s_r.mask[NUM_PER:1];
  assign ext_gated = s_r.pend[NUM_PER] & s_r.mask[MASK_EXT_BIT];
  // Pin reset is asynchronous in the real part; here it joins rst without a stage
  assign ext_rst = ~reset_pin_n;
  // Pin or watchdog reset caught in halt or stabilisation waits the long delay
  assign halt_rst = ~rst & (ext_rst | wdg_reset) &
    ((s_r.pst == PS_HALT) | (s_r.pst == PS_STAB));

  ipw_arbiter u_arb (
    .prio_fields({s_r.prio_hi, s_r.prio_lo}),
    .req(per_req),
    .ext_req(ext_gated),
    .found(arb_found),
    .code(arb_code),
    .level(arb_level)
  );

  ipw_stab_timer u_tmr (
    .mclk(mclk),
    .rst(rst),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic [NUM_PER:0] ev;
    logic gie;
    logic grant;
    logic do_take;
    logic [5:0] low_pick;
    s_nxt = s_r;
    s_nxt.take_irq = 1'b0;
    s_nxt.save_context = 1'b0;
    s_nxt.restore_context = 1'b0;
    s_nxt.program_restart = 1'b0;
    tmr_load = 1'b0;
    tmr_val = CNT_W'(STAB_INT);
    ev = {ext_request, sci_request, timer_two_request, timer_one_request,
          timer_zero_request, adc_request};
    gie = s_r.user_gie & s_r.macro_gie;
    // A request may preempt only a strictly less urgent running level
    grant = gie && arb_found && (arb_level < s_r.cur_level);
    do_take = 1'b0;
    low_pick = least_src({s_r.prio_hi, s_r.prio_lo});

    // Configuration writes; a new priority map takes effect at next arbitration
    if (cfg_we) begin
      case (cfg_addr)
        ADDR_PRIO_LOW: s_nxt.prio_lo = cfg_wdata;
        ADDR_PRIO_HIGH: s_nxt.prio_hi = cfg_wdata;
        ADDR_MASK: s_nxt.mask = cfg_wdata;
        default: ;
      endcase
    end
    if (user_global_disable) s_nxt.user_gie = 1'b0;
    if (user_global_enable) s_nxt.user_gie = 1'b1;
    if (macro_global_disable) s_nxt.macro_gie = 1'b0;
    if (macro_global_enable) s_nxt.macro_gie = 1'b1;

    // Clear-pending by index; an event in the same cycle wins
    if (clear_pending_instruction && clear_index < 3'(NUM_PER)) begin
      s_nxt.pend[clear_index] = 1'b0;
      // Clearing own request drops the running routine to least urgent
      if (clear_index == s_r.cur_code && s_r.cur_level != LEVEL_MAIN) begin
        s_nxt.cur_level = LEVEL_MAIN;
      end
    end
    // Halt freezes peripherals, so only the pin can raise a request there
    if (s_r.pst == PS_HALT) begin
      s_nxt.pend[NUM_PER] = s_nxt.pend[NUM_PER] | ev[NUM_PER];
    end else begin
      s_nxt.pend = s_nxt.pend | ev;
    end

    // Return pops the interrupted level; execution resumes after the break point
    if (return_instr && s_r.sp != 3'h0) begin
      s_nxt.sp = s_r.sp - 3'h1;
      s_nxt.cur_level = s_r.stack[s_r.sp - 3'h1][5:3];
      s_nxt.cur_code = s_r.stack[s_r.sp - 3'h1][2:0];
      s_nxt.restore_context = 1'b1;
    end

    case (s_r.pst)
      PS_RUN: begin
        // Arbitrate only at instruction end; a take outranks a power instruction
        if (alu_instr_end && grant) begin
          do_take = 1'b1;
        end else if (wait_instr) begin
          s_nxt.pst = PS_WAIT;
        end else if (halt_instr && !wdg_enabled) begin
          s_nxt.pst = PS_HALT;
        end
      end
      PS_WAIT: begin
        // The core is stopped, so a winning request vectors at once
        if (grant) begin
          do_take = 1'b1;
          s_nxt.pst = PS_RUN;
        end else if (s_r.pend != '0) begin
          // Any other pending source, masked or outranked, still wakes
          s_nxt.pst = PS_RUN;
        end
      end
      PS_HALT: begin
        if (s_r.pend[NUM_PER]) begin
          s_nxt.pst = PS_STAB;
          s_nxt.halt_by_ext = 1'b1;
          tmr_load = 1'b1;
          tmr_val = CNT_W'(STAB_INT);
        end
      end
      PS_STAB: begin
        if (tmr_done) begin
          s_nxt.pst = PS_RUN;
          if (s_r.halt_by_ext) begin
            s_nxt.halt_by_ext = 1'b0;
            s_nxt.take_irq = 1'b1;
            s_nxt.save_context = 1'b1;
            s_nxt.stack[s_r.sp] = {s_r.cur_level, s_r.cur_code};
            s_nxt.sp = s_r.sp + 3'h1;
            if (s_r.mask[MASK_EXT_BIT]) begin
              s_nxt.vector_addr = vec_of(CODE_EXT);
              s_nxt.cur_level = 3'h0;
              s_nxt.cur_code = CODE_EXT;
              s_nxt.pend[NUM_PER] = ev[NUM_PER];
            end else begin
              // Masked pin still wakes; the least urgent assigned routine runs
              s_nxt.vector_addr = vec_of(low_pick[2:0]);
              s_nxt.cur_level = low_pick[5:3];
              s_nxt.cur_code = low_pick[2:0];
            end
          end else begin
            s_nxt.program_restart = 1'b1;
          end
        end
      end
      default: s_nxt.pst = PS_RUN;
    endcase

    // Vector to the winner: push the running level, consume its request
    if (do_take) begin
      s_nxt.take_irq = 1'b1;
      s_nxt.save_context = 1'b1;
      s_nxt.vector_addr = vec_of(arb_code);
      s_nxt.stack[s_r.sp] = {s_r.cur_level, s_r.cur_code};
      s_nxt.sp = s_r.sp + 3'h1;
      s_nxt.cur_level = arb_level;
      s_nxt.cur_code = arb_code;
      // A fresh event of the same source in this cycle stays pending
      s_nxt.pend[arb_code] = ev[arb_code];
    end

    // Reset out of halt restarts the oscillator and counts the long delay
    if (halt_rst) begin
      tmr_load = 1'b1;
      tmr_val = CNT_W'(STAB_RST);
    end

    // Register readback
    case (rd_addr)
      ADDR_PRIO_LOW: s_nxt.rd_data = s_r.prio_lo;
      ADDR_PRIO_HIGH: s_nxt.rd_data = s_r.prio_hi;
      ADDR_MASK: s_nxt.rd_data = s_r.mask;
      default: s_nxt.rd_data = 8'h00;
    endcase

    // Power decode is registered so the pins never glitch on a state change
    s_nxt.cpu_run = (s_nxt.pst == PS_RUN);
    s_nxt.osc_en = (s_nxt.pst != PS_HALT);
    s_nxt.periph_en = (s_nxt.pst == PS_RUN) || (s_nxt.pst == PS_WAIT);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Every reset source reloads the bank; a pin or watchdog one caught in halt or stabilisation goes to stabilisation
  always_ff @(posedge mclk) begin
    if (rst || ext_rst || wdg_reset) begin
      s_r <= '0;
      s_r.prio_lo <= PRIO_RESET;
      s_r.prio_hi <= PRIO_RESET;
      s_r.mask <= MASK_RESET;
      s_r.user_gie <= 1'b1;
      s_r.macro_gie <= 1'b1;
      s_r.cur_level <= LEVEL_MAIN;
      s_r.pst <= halt_rst ? PS_STAB : PS_RUN;
      s_r.program_restart <= ~halt_rst;
      // Outputs come up as in run unless the reset caught the core in halt or stabilisation
      s_r.cpu_run <= ~halt_rst;
      s_r.osc_en <= 1'b1;
      s_r.periph_en <= ~halt_rst;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rd_data = s_r.rd_data;
  assign take_irq = s_r.take_irq;
  assign vector_addr = s_r.vector_addr;
  assign active_level = s_r.cur_level;
  assign save_context = s_r.save_context;
  assign restore_context = s_r.restore_context;
  assign cpu_run = s_r.cpu_run;
  assign osc_enable = s_r.osc_en;
  assign periph_enable = s_r.periph_en;
  assign program_restart = s_r.program_restart;
  assign power_state = s_r.pst;

endmodule

// ===== testbench.sv
// Self-checking bench for the interrupt priority and power wake block
`timescale 1ns/100ps
module testbench;
  import ipw_pkg::*;
  localparam int SI = 16;
  localparam int SR = 32;
  logic mclk, rst, reset_pin_n, wdg_reset, wdg_enabled, take_irq, save_context;
  logic restore_context, cpu_run, osc_enable, periph_enable, program_restart;
  logic [7:0] cfg_addr, cfg_wdata, rd_addr, rd_data, vector_addr;
  logic [9:0] ev;
  logic [5:0] fire, req;
  logic [2:0] clear_index, active_level;
  logic [3:0] power_state;
  int miscompares, samples_checked, n;
  ipw_top #(.STAB_INT(SI), .STAB_RST(SR)) dut_u (.mclk(mclk), .rst(rst),
    .reset_pin_n(reset_pin_n), .wdg_reset(wdg_reset), .wdg_enabled(wdg_enabled),
    .cfg_we(ev[9]), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .rd_addr(rd_addr),
    .rd_data(rd_data), .adc_request(req[0]), .timer_zero_request(req[1]),
    .timer_one_request(req[2]), .timer_two_request(req[3]), .sci_request(req[4]),
    .ext_request(req[5]), .alu_instr_end(ev[0]), .return_instr(ev[1]),
    .clear_pending_instruction(ev[2]), .clear_index(clear_index), .wait_instr(ev[3]),
    .halt_instr(ev[4]), .user_global_disable(ev[5]), .user_global_enable(ev[6]),
    .macro_global_disable(ev[7]), .macro_global_enable(ev[8]), .take_irq(take_irq),
    .vector_addr(vector_addr), .active_level(active_level), .save_context(save_context),
    .restore_context(restore_context), .cpu_run(cpu_run), .osc_enable(osc_enable),
    .periph_enable(periph_enable), .program_restart(program_restart),
    .power_state(power_state));
  ipw_src_model src_u (.mclk(mclk), .rst(rst), .fire(fire), .req(req));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
      miscompares++;
    end
  endtask
  // Event strobes rise after one edge and fall after the next
  task automatic pulse(input int b);
    @(posedge mclk) ev[b] <= 1'b1;
    @(posedge mclk) ev[b] <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cfg_addr <= a;
    cfg_wdata <= d;
    pulse(9);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk) rd_addr <= a;
    @(posedge mclk);
    #1;
    chk("rd_data", e, rd_data);
  endtask
  task automatic src(input logic [5:0] m);
    @(posedge mclk) fire <= m;
    @(posedge mclk) fire <= 6'h00;
    #1;
  endtask
  task automatic take(input logic [7:0] v, input logic [2:0] l);
    pulse(0);
    chk("take_irq", 8'h01, take_irq);
    chk("vector_addr", v, vector_addr);
    chk("active_level", l, active_level);
    chk("save_context", 8'h01, save_context);
  endtask
  task automatic notake;
    pulse(0);
    chk("take_irq", 8'h00, take_irq);
  endtask
  task automatic ret;
    pulse(1);
    chk("restore_context", 8'h01, restore_context);
  endtask
  // Bounded wait, since wake-up takes no instruction strobe
  task automatic waitake;
    n = 0;
    while (take_irq !== 1'b1 && n < 100) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    chk("active_level", 8'h06, active_level);
    rd(8'h11, 8'h00);
    rd(8'h12, 8'h00);
    wr(8'h11, 8'hC1);
    wr(8'h12, 8'hA8);
    wr(8'h00, 8'h3F);
    rd(8'h11, 8'hC1);
    rd(8'h12, 8'hA8);
    rd(8'h55, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_prio;
    src(6'h03);
    take(8'h06, 3'h1);
    notake();
    ret();
    take(8'h03, 3'h2);
    ret();
    chk("active_level", 8'h06, active_level);
    $display("test prio done");
  endtask
  task automatic t_mask;
    wr(8'h00, 8'h1F);
    src(6'h10);
    notake();
    wr(8'h00, 8'h3F);
    take(8'h0F, 3'h4);
    ret();
    $display("test mask done");
  endtask
  // Globals are masked around each clear, both user and macro kinds
  task automatic t_clear;
    src(6'h04);
    pulse(5);
    clear_index <= 3'h2;
    pulse(2);
    pulse(6);
    notake();
    src(6'h08);
    pulse(7);
    clear_index <= 3'h5;
    pulse(2);
    pulse(8);
    take(8'h0C, 3'h3);
    pulse(5);
    clear_index <= 3'h3;
    pulse(2);
    pulse(6);
    chk("active_level", 8'h06, active_level);
    ret();
    $display("test clear done");
  endtask
  task automatic t_ext;
    src(6'h20);
    take(8'h12, 3'h0);
    ret();
    $display("test ext done");
  endtask
  task automatic t_wait;
    pulse(3);
    chk("power_state", 8'h02, power_state);
    src(6'h01);
    waitake();
    chk("vector_addr", 8'h03, vector_addr);
    chk("power_state", 8'h01, power_state);
    ret();
    $display("test wait done");
  endtask
  task automatic t_halt;
    wdg_enabled <= 1'b1;
    pulse(4);
    chk("power_state", 8'h01, power_state);
    wdg_enabled <= 1'b0;
    pulse(4);
    chk("power_state", 8'h04, power_state);
    chk("osc_enable", 8'h00, osc_enable);
    src(6'h02);
    @(posedge mclk);
    #1;
    chk("power_state", 8'h04, power_state);
    src(6'h20);
    waitake();
    chk("vector_addr", 8'h12, vector_addr);
    chk("stab_span", 8'h01, {7'h00, n >= SI && n <= SI + 8});
    ret();
    notake();
    // Masked pin still wakes, but the least urgent routine runs
    wr(8'h00, 8'h3E);
    pulse(4);
    src(6'h20);
    waitake();
    chk("vector_addr", 8'h09, vector_addr);
    chk("active_level", 8'h05, active_level);
    ret();
    $display("test halt done");
  endtask
  // Pin reset first, then watchdog reset
  task automatic t_rst;
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      reset_pin_n <= (i != 0);
      wdg_reset <= (i == 1);
      @(posedge mclk);
      reset_pin_n <= 1'b1;
      wdg_reset <= 1'b0;
      #1;
      chk("active_level", 8'h06, active_level);
      n = 0;
      while (program_restart !== 1'b1 && n < 4) begin
        @(posedge mclk);
        #1;
        n++;
      end
      chk("program_restart", 8'h01, program_restart);
      rd(8'h11, 8'h00);
    end
    // Reset caught in halt must still wait out the long oscillator delay
    pulse(4);
    @(posedge mclk) reset_pin_n <= 1'b0;
    @(posedge mclk) reset_pin_n <= 1'b1;
    #1;
    chk("power_state", 8'h08, power_state);
    n = 0;
    while (program_restart !== 1'b1 && n < 100) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("rst_span", 8'h01, {7'h00, n >= SR && n <= SR + 8});
    $display("test reset done");
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Whole run needs well under two thousand cycles
  initial begin
    #(8 * 20000);
    miscompares++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    reset_pin_n = 1'b1;
    wdg_reset = 1'b0;
    wdg_enabled = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
    rd_addr = 8'h00;
    ev = 10'h000;
    fire = 6'h00;
    clear_index = 3'h0;
    miscompares = 0;
    samples_checked = 0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    t_regs();
    t_prio();
    t_mask();
    t_clear();
    t_ext();
    t_wait();
    t_halt();
    t_rst();
    wrap_up();
  end
endmodule
